// ===== core/asrwb_pkg.sv
// Behaviour
// - Write strobe stays high during reads.
// - Reads valid by 45 ns; spacing 45 ns.
// - Write needs all strobes; starts at last.
// - Write ends at first inactive strobe.
// - Address, select, strobe held 35 ns.
// - Byte select low 35 ns before end.
// - Data setup 25 ns, hold 0 ns.
// - Address edges free; write cycle 45 ns.
// - Never drive data while memory drives.
// - No byte select toggles while deselected.
package asrwb_pkg;

  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int ADDR_W = 17; // 128K words
  localparam int DATA_W = 16; // Two byte lanes
  localparam int BE_W = 2; // One enable per lane
  localparam int SYNC_STAGES = 2; // Pin synchroniser depth

  // ==========================================================
  // Timing in nanoseconds
  // ==========================================================
  localparam int CLK_PERIOD_NS = 100; // 10 MHz
  localparam int T_RC_NS = 45; // Read cycle minimum
  localparam int T_AA_NS = 45; // Address to data valid
  localparam int T_ACE_NS = 45; // Select to data valid
  localparam int T_DOE_NS = 22; // Output drive to data valid
  localparam int T_DBE_NS = 22; // Byte select to data valid
  localparam int T_WC_NS = 45; // Write cycle minimum
  localparam int T_SCE_NS = 35; // Select to write end
  localparam int T_AW_NS = 35; // Address setup to write end
  localparam int T_PWE_NS = 35; // Strobe pulse width
  localparam int T_BW_NS = 35; // Byte select to write end
  localparam int T_SD_NS = 25; // Data setup to write end
  localparam int T_HZ_NS = 18; // Memory release of the bus

  // Minimum time to whole cycles, rounded up, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ==========================================================
  // Derived cycle counts
  // ==========================================================
  // Longest valid-data delay, then the synchroniser latency
  localparam int RD_ACC_CYC = max2(max2(ns2cyc(T_AA_NS),
    ns2cyc(T_ACE_NS)), max2(max2(ns2cyc(T_DOE_NS),
    ns2cyc(T_DBE_NS)), ns2cyc(T_RC_NS)));
  localparam int RD_CYC = RD_ACC_CYC + SYNC_STAGES;
  localparam int WR_CYC = max2(max2(max2(ns2cyc(T_WC_NS),
    ns2cyc(T_SCE_NS)), max2(ns2cyc(T_AW_NS), ns2cyc(T_PWE_NS))),
    max2(ns2cyc(T_BW_NS), ns2cyc(T_SD_NS)));
  localparam int GAP_CYC = ns2cyc(T_HZ_NS); // Bus turnaround
  localparam int TMR_W = 4; // Timer width

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_GAP = 4'h8
  } asrwb_state_t;

  // Pins toward the memory, strobes active low
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_sel_n;
    logic write_strobe_n;
    logic out_drive_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
  } asrwb_pins_t;

  // User request: byte enables active high
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } asrwb_req_t;

  localparam asrwb_pins_t PINS_IDLE = '{
    addr: 17'h00000, chip_sel_n: 1'b1, write_strobe_n: 1'b1,
    out_drive_n: 1'b1, upper_byte_sel_n: 1'b1,
    lower_byte_sel_n: 1'b1};

endpackage

// ===== core/asrwb_timer.sv
`timescale 1ns/1ps
module asrwb_timer #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [W-1:0] count_in,
  output logic done_out
);
  import asrwb_pkg::*;

  // ==========================================================
  // Down counter: done while the count is zero
  // ==========================================================
  logic [W-1:0] cnt_r; // Remaining cycles
  logic [W-1:0] cnt_nxt;

  // Next count: load wins, else count down to zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_in) begin
      cnt_nxt = count_in;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Register only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_out = (cnt_r == '0);

endmodule

// ===== core/asrwb_ctrl.sv
`timescale 1ns/1ps
module asrwb_ctrl (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire asrwb_pkg::asrwb_req_t req_in,
  output logic ready_out,
  output logic rvalid_out,
  output logic [asrwb_pkg::DATA_W-1:0] rdata_out,
  output asrwb_pkg::asrwb_pins_t pins_out,
  input wire logic [asrwb_pkg::DATA_W-1:0] sram_data_in,
  output logic [asrwb_pkg::DATA_W-1:0] sram_data_out,
  output logic sram_data_oe_out
);
  import asrwb_pkg::*;

  // ==========================================================
  // Cycle counts handed to the timer
  // ==========================================================
  localparam logic [TMR_W-1:0] RD_LOAD = TMR_W'(RD_CYC - 1);
  localparam logic [TMR_W-1:0] WR_LOAD = TMR_W'(WR_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(GAP_CYC - 1);

  // ==========================================================
  // State
  // ==========================================================
  asrwb_state_t state_r; // Sequencer state
  asrwb_state_t state_nxt;
  asrwb_pins_t pins_r; // Registered memory pins
  asrwb_pins_t pins_nxt;
  logic [DATA_W-1:0] wdata_r; // Write data on the bus
  logic [DATA_W-1:0] wdata_nxt;
  logic data_oe_r; // We drive the data bus
  logic data_oe_nxt;
  logic [DATA_W-1:0] rdata_r; // Captured read word
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r; // One-cycle read answer
  logic rvalid_nxt;
  logic [DATA_W-1:0] sync1_r; // First stage, read only by sync2
  logic [DATA_W-1:0] sync2_r; // Safe copy of the data pins
  logic tmr_load; // Start a timed phase
  logic [TMR_W-1:0] tmr_count;
  logic tmr_done; // Phase time has elapsed

  // ==========================================================
  // Phase timer
  // ==========================================================
  asrwb_timer #(
    .W(TMR_W)
  ) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  // ==========================================================
  // Data pin synchroniser
  // ==========================================================
  // Pins are asynchronous to us, so two flops before any use
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= sram_data_in;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // Sequencer next state
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    pins_nxt = pins_r;
    wdata_nxt = wdata_r;
    data_oe_nxt = data_oe_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_count = GAP_LOAD;
    case (state_r)
      // Accept a request and raise select, enabled byte selects and write strobe or output drive on one edge
      ST_IDLE: begin
        if (req_valid_in) begin
          tmr_load = 1'b1;
          pins_nxt.addr = req_in.addr;
          pins_nxt.chip_sel_n = 1'b0;
          pins_nxt.upper_byte_sel_n = ~req_in.be[1];
          pins_nxt.lower_byte_sel_n = ~req_in.be[0];
          if (req_in.write) begin
            pins_nxt.write_strobe_n = 1'b0;
            // output drive off while we drive
            pins_nxt.out_drive_n = 1'b1;
            data_oe_nxt = 1'b1;
            wdata_nxt = req_in.wdata;
            tmr_count = WR_LOAD;
            state_nxt = ST_WRITE;
          end else begin
            pins_nxt.write_strobe_n = 1'b1;
            pins_nxt.out_drive_n = 1'b0;
            tmr_count = RD_LOAD;
            state_nxt = ST_READ;
          end
        end
      end
      // Hold the read until synchronised data is valid
      ST_READ: begin
        if (tmr_done) begin
          rdata_nxt = sync2_r;
          rvalid_nxt = 1'b1;
          pins_nxt.chip_sel_n = 1'b1;
          pins_nxt.out_drive_n = 1'b1;
          pins_nxt.upper_byte_sel_n = 1'b1;
          pins_nxt.lower_byte_sel_n = 1'b1;
          tmr_load = 1'b1;
          state_nxt = ST_GAP;
        end
      end
      // End the write on one edge; address kept for hold
      ST_WRITE: begin
        if (tmr_done) begin
          pins_nxt.chip_sel_n = 1'b1;
          pins_nxt.write_strobe_n = 1'b1;
          pins_nxt.upper_byte_sel_n = 1'b1;
          pins_nxt.lower_byte_sel_n = 1'b1;
          data_oe_nxt = 1'b0;
          tmr_load = 1'b1;
          state_nxt = ST_GAP;
        end
      end
      // Idle gap lets the memory release the bus first
      ST_GAP: begin
        if (tmr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Register only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
      pins_r <= PINS_IDLE;
      wdata_r <= 16'h0000;
      data_oe_r <= 1'b0;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
      wdata_r <= wdata_nxt;
      data_oe_r <= data_oe_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign ready_out = (state_r == ST_IDLE);
  assign rvalid_out = rvalid_r;
  assign rdata_out = rdata_r;
  assign pins_out = pins_r;
  assign sram_data_out = wdata_r;
  assign sram_data_oe_out = data_oe_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_rd_held;
    (!pins_r.chip_sel_n && pins_r.write_strobe_n
      && !pins_r.out_drive_n)[*3];
  endsequence

  sequence s_wr_ended;
    pins_r.chip_sel_n && pins_r.write_strobe_n && !data_oe_r;
  endsequence

  property p_we_high_read;
    !pins_r.out_drive_n |-> pins_r.write_strobe_n;
  endproperty
  a_we_high_read: assert property (p_we_high_read)
    else $error("write strobe low during read");

  property p_read_len;
    $fell(pins_r.chip_sel_n) && pins_r.write_strobe_n
      |-> s_rd_held ##1 pins_r.chip_sel_n;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read cycle length wrong");

  property p_wr_start;
    $fell(pins_r.write_strobe_n) |-> !pins_r.chip_sel_n
      && $fell(pins_r.chip_sel_n) && data_oe_r;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write strobes not raised together");

  property p_wr_end;
    $rose(pins_r.write_strobe_n) |-> s_wr_ended
      and (pins_r.upper_byte_sel_n && pins_r.lower_byte_sel_n);
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write not ended on one edge");

  property p_wr_width;
    $fell(pins_r.write_strobe_n) |=> $rose(pins_r.write_strobe_n)
      && $stable(pins_r.addr);
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe width or address wrong");

  property p_bs_write;
    !pins_r.write_strobe_n |-> ((pins_r.upper_byte_sel_n
      == ~$past(req_in.be[1])) && (pins_r.lower_byte_sel_n
      == ~$past(req_in.be[0]))) || $stable(pins_r.write_strobe_n);
  endproperty
  a_bs_write: assert property (p_bs_write)
    else $error("byte select does not match request");

  property p_data_setup;
    // Data is the request's word while the strobe is low, and it
    // stays unchanged through the terminating edge
    !pins_r.write_strobe_n |-> (data_oe_r
      && (sram_data_out == $past(req_in.wdata)))
      ##1 (!data_oe_r && $stable(sram_data_out));
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("write data not held over strobe");

  property p_no_fight;
    data_oe_r |-> pins_r.out_drive_n && $past(pins_r.out_drive_n);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("bus driven while memory may drive");

  property p_bs_idle;
    pins_r.chip_sel_n |-> pins_r.upper_byte_sel_n
      && pins_r.lower_byte_sel_n;
  endproperty
  a_bs_idle: assert property (p_bs_idle)
    else $error("byte select active while deselected");

  property p_sample_late;
    rvalid_r |-> !$past(pins_r.chip_sel_n, 3)
      && $past(pins_r.chip_sel_n, 4);
  endproperty
  a_sample_late: assert property (p_sample_late)
    else $error("read data sampled too early");

  property p_gap;
    $rose(pins_r.chip_sel_n) |-> !ready_out ##1 ready_out;
  endproperty
  a_gap: assert property (p_gap)
    else $error("turnaround gap wrong");

endmodule

// ===== sim/asrwb_sram_model.sv
`timescale 1ns/1ps
// ==========================================================
// Behavioural word/byte static memory on the far side
// ==========================================================
module asrwb_sram_model (
  input wire asrwb_pkg::asrwb_pins_t pins_in,
  input wire logic [asrwb_pkg::DATA_W-1:0] data_in,
  input wire logic slow_in,
  output logic [asrwb_pkg::DATA_W-1:0] data_out,
  output logic [1:0] drive_out
);
  import asrwb_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Storage, no reset
  logic [DATA_W-1:0] last = '0; // Last value driven per lane
  logic [DATA_W-1:0] nxt; // Lane values before the output delay
  logic sel; // Chip selected
  logic wr_act; // Write overlap open
  logic rd_act; // Read conditions met
  int dly; // Output delay; slow sits at the tightest limit

  assign sel = !pins_in.chip_sel_n;
  assign wr_act = sel && !pins_in.write_strobe_n &&
    !(pins_in.upper_byte_sel_n && pins_in.lower_byte_sel_n);
  assign rd_act = sel && pins_in.write_strobe_n && !pins_in.out_drive_n;
  assign drive_out = {rd_act && !pins_in.upper_byte_sel_n,
    rd_act && !pins_in.lower_byte_sel_n};
  assign dly = slow_in ? 22 : 10;

  // ==========================================================
  // Write: select, write strobe or both byte selects going inactive closes the overlap
  // ==========================================================
  // store selected lanes
  always @* begin
    if (wr_act) begin
      if (!pins_in.lower_byte_sel_n) begin
        mem[pins_in.addr][7:0] = data_in[7:0];
      end
      if (!pins_in.upper_byte_sel_n) begin
        mem[pins_in.addr][15:8] = data_in[15:8];
      end
    end
  end

  // Released lanes show the inverse of their last value, so a
  // controller that samples a floating bus sees wrong data
  always @* begin
    if (drive_out[0]) begin
      last[7:0] = mem[pins_in.addr][7:0];
    end
    if (drive_out[1]) begin
      last[15:8] = mem[pins_in.addr][15:8];
    end
    nxt[7:0] = drive_out[0] ? last[7:0] : ~last[7:0];
    nxt[15:8] = drive_out[1] ? last[15:8] : ~last[15:8];
  end

  always @(nxt) begin
    data_out <= #(dly) nxt;
  end
endmodule

// ===== sim/async_sram_word_byte_access_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the memory controller
// ==========================================================
module async_sram_word_byte_access_bench;
  import asrwb_pkg::*;
  logic clk_in; // 10 MHz clock
  logic resetn_in; // Active-low reset
  logic req_valid; // Request strobe
  asrwb_req_t req; // Request body
  logic ready, rvalid; // User handshake
  logic [DATA_W-1:0] rdata, sram_din, sram_dout, mem_data;
  asrwb_pins_t pins; // Strobes toward the memory
  logic sram_oe, slow; // Bus drive, slow memory
  logic [1:0] mem_drv; // Lanes driven by the memory
  logic [DATA_W-1:0] exp_mem [int]; // Expected contents
  int fail_count = 0;
  int n_compared = 0;

  // Wire level: whoever enables drives the bus
  assign sram_din = sram_oe ? sram_dout : mem_data;

  asrwb_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .req_valid_in(req_valid), .req_in(req), .ready_out(ready),
    .rvalid_out(rvalid), .rdata_out(rdata), .pins_out(pins),
    .sram_data_in(sram_din), .sram_data_out(sram_dout),
    .sram_data_oe_out(sram_oe));
  asrwb_sram_model i_mem (.pins_in(pins), .data_in(sram_dout),
    .slow_in(slow), .data_out(mem_data), .drive_out(mem_drv));

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded wait for the controller to go idle
  task automatic wait_ready;
    int i;
    i = 0;
    @(negedge clk_in);
    while (ready !== 1'b1 && i < 50) begin
      @(negedge clk_in);
      i++;
    end
    if (i >= 50) begin
      fail_count++;
      finish_test();
    end
  endtask

  // Returns just after the taking edge
  task automatic send(input logic w, input logic [16:0] a,
    input logic [15:0] d, input logic [1:0] be);
    wait_ready();
    @(posedge clk_in);
    req_valid <= 1'b1;
    req <= '{write: w, addr: a, wdata: d, be: be};
    @(posedge clk_in);
    req_valid <= 1'b0;
  endtask

  task automatic do_write(input logic [16:0] a, input logic [15:0] d,
    input logic [1:0] be);
    send(1'b1, a, d, be);
    @(negedge clk_in);
    chk("wr pins", pins, {a, 3'b001, ~be});
    chk("wr bus", {sram_oe, sram_dout}, {1'b1, d});
    @(negedge clk_in);
    chk("wr end", pins, {a, 5'h1F});
    chk("wr release", {sram_oe, ready}, 2'b00);
    @(negedge clk_in);
    chk("wr ready", ready, 1'b1);
    if (be[0]) exp_mem[a][7:0] = d[7:0];
    if (be[1]) exp_mem[a][15:8] = d[15:8];
  endtask

  task automatic do_read(input logic [16:0] a, input logic [1:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    send(1'b0, a, 16'hFFFF, be);
    @(negedge clk_in);
    chk("rd pins", pins, {a, 3'b010, ~be});
    chk("rd bus off", sram_oe, 1'b0);
    repeat (2) begin
      @(negedge clk_in);
      chk("rd early", rvalid, 1'b0);
    end
    @(negedge clk_in);
    chk("rd valid", {rvalid, ready, pins[4:0]}, 7'h5F);
    chk("rd data", rdata & m, exp_mem[a] & m);
    @(negedge clk_in);
    chk("rd done", {rvalid, ready}, 2'b01);
  endtask

  // Every lane code at both ends of the address range
  task automatic sc_lanes;
    logic [16:0] adr [3];
    adr = '{17'h00000, 17'h1FFFF, 17'h0AAAA};
    foreach (adr[i]) begin
      do_write(adr[i], 16'h5AA5 ^ 16'(i), 2'h3);
      for (int b = 0; b < 4; b++) begin
        do_write(adr[i], 16'h1234 + 16'(b * 16'h1111), 2'(b));
        for (int r = 0; r < 4; r++) do_read(adr[i], 2'(r));
      end
    end
  endtask

  // Requests while busy must leave no trace
  task automatic sc_refuse;
    do_write(17'h00100, 16'hC3C3, 2'h3);
    send(1'b0, 17'h00100, 16'h0000, 2'h3);
    @(posedge clk_in);
    req_valid <= 1'b1;
    req <= '{write: 1'b1, addr: 17'h00100, wdata: 16'h0F0F, be: 2'h3};
    repeat (3) @(posedge clk_in);
    req_valid <= 1'b0;
    do_read(17'h00100, 2'h3);
  endtask

  // Reset in mid-read returns every pin to idle
  task automatic sc_midreset;
    send(1'b0, 17'h00100, 16'h0000, 2'h3);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    @(negedge clk_in);
    chk("rst pins", pins, PINS_IDLE);
    chk("rst flags", {sram_oe, rvalid, ready, rdata}, 19'h10000);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    do_read(17'h00100, 2'h3);
  endtask

  // Selects never move while deselected; no bus clash
  always @(negedge clk_in) begin
    if (resetn_in === 1'b1) begin
      if (pins.chip_sel_n) chk("idle sel", pins[1:0], 2'b11);
      if (sram_oe) chk("clash", mem_drv, 2'b00);
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    resetn_in = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    repeat (20) @(posedge clk_in);
    chk("reset pins", pins, PINS_IDLE);
    resetn_in <= 1'b1;
    sc_lanes();
    @(posedge clk_in);
    slow <= 1'b1;
    sc_lanes();
    sc_refuse();
    sc_midreset();
    finish_test();
  end
endmodule
